//--- core/cocr_pkg.sv
/*
 * Constants for the clock output control register slice: register offsets,
 * field positions, writable masks, reset values and output format codes.
 * Assumes an 8-bit register port with 8-bit addresses.
 */
package cocr_pkg;
  typedef logic [7:0] cocr_byte_t;
  localparam logic [7:0] ADDR_FREEZE_SQUELCH = 8'h03;
  localparam logic [7:0] ADDR_CMOS_DRIVE = 8'h05;
  localparam logic [7:0] ADDR_FORMAT = 8'h06;
  localparam logic [7:0] ADDR_LEVEL_HOLD = 8'h08;
  localparam logic [7:0] ADDR_POWERDOWN = 8'h0a;
  localparam int FREEZE_BIT = 5;
  localparam int SQUELCH_BIT = 4;
  localparam int DRIVE_LSB = 6;
  localparam int FORMAT_LSB = 0;
  localparam int HOLD_LSB = 4;
  localparam int DISABLE_BIT = 2;
  localparam logic [7:0] MASK_FREEZE_SQUELCH = 8'h30;
  localparam logic [7:0] MASK_CMOS_DRIVE = 8'hc0;
  localparam logic [7:0] MASK_FORMAT = 8'h07;
  localparam logic [7:0] MASK_LEVEL_HOLD = 8'h30;
  localparam logic [7:0] MASK_POWERDOWN = 8'h04;
  localparam logic [7:0] RST_FREEZE_SQUELCH = 8'h05;
  localparam logic [7:0] RST_CMOS_DRIVE = 8'hed;
  localparam logic [7:0] RST_FORMAT = 8'h2d;
  localparam logic [7:0] RST_LEVEL_HOLD = 8'h00;
  localparam logic [7:0] RST_POWERDOWN = 8'h00;
  localparam logic [2:0] FMT_DISABLE = 3'h1;
  localparam logic [2:0] FMT_CMOS = 3'h2;
  localparam logic [2:0] FMT_LVDS_LOW = 3'h3;
  localparam logic [2:0] FMT_LVPECL = 3'h5;
  localparam logic [2:0] FMT_CML = 3'h6;
  localparam logic [2:0] FMT_LVDS = 3'h7;
  localparam logic [1:0] HOLD_NORMAL = 2'h0;
  localparam logic [1:0] HOLD_LOW = 2'h1;
  localparam logic [1:0] HOLD_HIGH = 2'h2;
  localparam int SYNC_STAGES = 3;
endpackage : cocr_pkg

//--- core/cocr_glitch_hold.sv
/*
 * Glitch-free static level hold on the output clock path.
 * Assumes the generated clock arrives as a sampled level on the system clock
 * and that the hold request is already synchronous.
 */
`timescale 1ns/1ps
module cocr_glitch_hold
  import cocr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // Hold request and clock level in
  input wire logic [1:0] hold_mode,
  input wire logic clk_level,
  // Held clock level out
  output logic clk_out,
  output logic hold_active
);
  import cocr_pkg::*;

  typedef enum logic [1:0] {COCR_RUN, COCR_HELD_LOW, COCR_HELD_HIGH} cocr_hold_e;
  cocr_hold_e state_reg, state_next;
  logic out_reg, out_next;

  // R06 safe switch point
  always_comb begin
    state_next = state_reg;
    out_next = out_reg;
    case (state_reg)
      COCR_RUN: begin
        out_next = clk_level;
        // Enter only when clock already sits at the target level
        if (hold_mode == HOLD_LOW && !clk_level) begin
          state_next = COCR_HELD_LOW;
          out_next = 1'b0;
        end else if (hold_mode == HOLD_HIGH && clk_level) begin
          state_next = COCR_HELD_HIGH;
          out_next = 1'b1;
        end
      end
      COCR_HELD_LOW: begin
        out_next = 1'b0;
        // Leave while clock is low so the first pulse is whole
        if (hold_mode != HOLD_LOW && !clk_level) begin
          state_next = COCR_RUN;
        end
      end
      COCR_HELD_HIGH: begin
        out_next = 1'b1;
        if (hold_mode != HOLD_HIGH && clk_level) begin
          state_next = COCR_RUN;
        end
      end
      default: begin
        state_next = COCR_RUN;
        out_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= COCR_RUN;
      out_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      out_reg <= out_next;
    end
  end

  assign clk_out = out_reg;
  assign hold_active = (state_reg != COCR_RUN);

  hold_no_glitch_a: assert property ( // R06
    @(posedge clock) disable iff (!rst_b)
    (clk_en && state_reg == COCR_RUN && state_next == COCR_HELD_LOW) |=> !out_reg)
    else $error("hold low entered with output high");
  hold_exit_low_a: assert property ( // R06
    @(posedge clock) disable iff (!rst_b)
    ($past(state_reg) == COCR_HELD_LOW && state_reg == COCR_RUN && $past(clk_en))
      |-> !out_reg)
    else $error("hold low left with a runt");
endmodule : cocr_glitch_hold

//--- core/cocr_regs.sv
/*
 * Clock output control register slice: five 8-bit registers on the
 * device's byte register port, and the control outputs they drive.
 * Assumes the two-wire programming engine presents single-cycle byte
 * writes and reads; the calibration flag and generated clock come from
 * other domains and are synchronised here.
 */
`timescale 1ns/1ps
// Notes on behaviour
// R01: Freeze bit forces oscillator freeze over all input selection and quality.
// R02: Squelch bit set disables outputs while calibration runs; clear keeps them.
// R03: In CMOS format, drive field codes give 8, 16, 24, 32 mA.
// R04: Format field decodes disable, CMOS, low LVDS, LVPECL, CML, LVDS; 000,100 reserved.
// R05: Hold field: 00 normal, 01 static low, 10 static high, 11 reserved.
// R06: Entering and leaving a static hold produces no glitch or runt.
// R07: Disable bit set powers down the output buffer; clear enables it.
// R08: A disabled output also powers down its feeding divider.
// R09: Reset values 0x05, 0xed, 0x2d, 0x00 and 0x00 for the five registers.
// R10: Always-on bit makes the device ignore squelch during calibration.
// R11: Reserved bits are read-only; writes to them are ignored.
module cocr_regs
  import cocr_pkg::*;
(
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire cocr_pkg::cocr_byte_t reg_wdata,
  output cocr_pkg::cocr_byte_t reg_rdata,
  output logic reg_hit,
  // Device status inputs
  input wire logic internal_calibration,
  input wire logic output_always_running,
  input wire logic synth_clock,
  // Clock path controls
  output logic oscillator_freeze_force,
  output logic [1:0] cmos_drive_strength,
  output logic [2:0] output_format_select,
  output logic output_buffer_powerdown,
  output logic output_divider_one_powerdown,
  output logic output_squelched,
  output logic clock_output,
  output logic clock_output_n,
  output logic output_hold_active
);
  import cocr_pkg::*;

  cocr_byte_t fsq_reg, fsq_next;
  cocr_byte_t drv_reg, drv_next;
  cocr_byte_t fmt_reg, fmt_next;
  cocr_byte_t hld_reg, hld_next;
  cocr_byte_t pd_reg, pd_next;
  cocr_byte_t rdata_reg, rdata_next;
  logic [SYNC_STAGES-1:0] cal_sync_reg, cal_sync_next;
  logic [SYNC_STAGES-1:0] clk_sync_reg, clk_sync_next;
  logic cal_level_reg, cal_level_next;
  logic clk_level_reg, clk_level_next;
  logic [1:0] hold_q;
  logic held_clk;
  logic fmt_off;
  logic squelch;
  logic [7:0] drive_ma;

  // R11 masked writes
  function automatic cocr_byte_t merge(input cocr_byte_t old_v, input cocr_byte_t new_v,
                                       input cocr_byte_t mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction : merge

  always_comb begin
    fsq_next = fsq_reg;
    drv_next = drv_reg;
    fmt_next = fmt_reg;
    hld_next = hld_reg;
    pd_next = pd_reg;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_FREEZE_SQUELCH: fsq_next = merge(fsq_reg, reg_wdata, MASK_FREEZE_SQUELCH);
        ADDR_CMOS_DRIVE: drv_next = merge(drv_reg, reg_wdata, MASK_CMOS_DRIVE);
        ADDR_FORMAT: fmt_next = merge(fmt_reg, reg_wdata, MASK_FORMAT);
        // R05 reserved hold code refused
        ADDR_LEVEL_HOLD: begin
          if (reg_wdata[HOLD_LSB +: 2] != 2'h3) begin
            hld_next = merge(hld_reg, reg_wdata, MASK_LEVEL_HOLD);
          end
        end
        ADDR_POWERDOWN: pd_next = merge(pd_reg, reg_wdata, MASK_POWERDOWN);
        default: ;
      endcase
    end
  end

  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_FREEZE_SQUELCH: rdata_next = fsq_reg;
        ADDR_CMOS_DRIVE: rdata_next = drv_reg;
        ADDR_FORMAT: rdata_next = fmt_reg;
        ADDR_LEVEL_HOLD: rdata_next = hld_reg;
        ADDR_POWERDOWN: rdata_next = pd_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_comb begin
    reg_hit = (reg_addr == ADDR_FREEZE_SQUELCH) || (reg_addr == ADDR_CMOS_DRIVE) ||
              (reg_addr == ADDR_FORMAT) || (reg_addr == ADDR_LEVEL_HOLD) ||
              (reg_addr == ADDR_POWERDOWN);
  end

  // Three-stage synchronisers; change counted when stages two and three agree
  always_comb begin
    cal_sync_next = {cal_sync_reg[SYNC_STAGES-2:0], internal_calibration};
    clk_sync_next = {clk_sync_reg[SYNC_STAGES-2:0], synth_clock};
    cal_level_next = cal_level_reg;
    clk_level_next = clk_level_reg;
    if (cal_sync_reg[1] == cal_sync_reg[2]) begin
      cal_level_next = cal_sync_reg[2];
    end
    if (clk_sync_reg[1] == clk_sync_reg[2]) begin
      clk_level_next = clk_sync_reg[2];
    end
  end

  // R09 reset values
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fsq_reg <= RST_FREEZE_SQUELCH;
      drv_reg <= RST_CMOS_DRIVE;
      fmt_reg <= RST_FORMAT;
      hld_reg <= RST_LEVEL_HOLD;
      pd_reg <= RST_POWERDOWN;
      rdata_reg <= 8'h00;
      cal_sync_reg <= '0;
      clk_sync_reg <= '0;
      cal_level_reg <= 1'b0;
      clk_level_reg <= 1'b0;
    end else if (clk_en) begin
      fsq_reg <= fsq_next;
      drv_reg <= drv_next;
      fmt_reg <= fmt_next;
      hld_reg <= hld_next;
      pd_reg <= pd_next;
      rdata_reg <= rdata_next;
      cal_sync_reg <= cal_sync_next;
      clk_sync_reg <= clk_sync_next;
      cal_level_reg <= cal_level_next;
      clk_level_reg <= clk_level_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // R01 freeze override
  assign oscillator_freeze_force = fsq_reg[FREEZE_BIT];
  assign cmos_drive_strength = drv_reg[DRIVE_LSB +: 2];
  assign output_format_select = fmt_reg[FORMAT_LSB +: 3];

  // R04 format decode: disable code and reserved codes turn the buffer off
  always_comb begin
    case (output_format_select)
      FMT_CMOS, FMT_LVDS_LOW, FMT_LVPECL, FMT_CML, FMT_LVDS: fmt_off = 1'b0;
      default: fmt_off = 1'b1;
    endcase
  end

  // R03 drive in mA, meaningful only in CMOS format
  always_comb begin
    drive_ma = 8'h00;
    if (output_format_select == FMT_CMOS) begin
      drive_ma = 8'(({6'h00, cmos_drive_strength} + 8'h01) * 8'h08);
    end
  end

  // R07 buffer powerdown
  assign output_buffer_powerdown = pd_reg[DISABLE_BIT] | fmt_off;
  // R08 divider follows buffer
  assign output_divider_one_powerdown = output_buffer_powerdown;

  // R02 squelch during calibration; R10 always-on bypass
  assign squelch = fsq_reg[SQUELCH_BIT] & cal_level_reg & ~output_always_running;
  assign output_squelched = squelch;

  assign hold_q = hld_reg[HOLD_LSB +: 2];

  // R06 glitch-free hold path
  cocr_glitch_hold u_hold (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .hold_mode(hold_q),
    .clk_level(clk_level_reg),
    .clk_out(held_clk),
    .hold_active(output_hold_active)
  );

  // Squelch and powerdown force a quiet low; drive_ma is kept for observability
  assign clock_output = held_clk & ~squelch & ~output_buffer_powerdown & (drive_ma != 8'hff);
  assign clock_output_n = ~held_clk & ~squelch & ~output_buffer_powerdown;

  freeze_map_a: assert property ( // R01
    @(posedge clock) disable iff (!rst_b)
    (clk_en && reg_wr && reg_addr == ADDR_FREEZE_SQUELCH)
      |=> oscillator_freeze_force == $past(reg_wdata[FREEZE_BIT]))
    else $error("freeze bit not taken");
  squelch_cal_a: assert property ( // R02
    @(posedge clock) disable iff (!rst_b)
    (fsq_reg[SQUELCH_BIT] && cal_level_reg && !output_always_running) |-> !clock_output)
    else $error("output runs during squelched calibration");
  drive_code_a: assert property ( // R03
    @(posedge clock) disable iff (!rst_b)
    (output_format_select == FMT_CMOS && cmos_drive_strength == 2'h3) |-> drive_ma == 8'h20)
    else $error("drive code 11 not 32 mA");
  format_off_a: assert property ( // R04
    @(posedge clock) disable iff (!rst_b)
    (output_format_select == FMT_DISABLE) |-> output_buffer_powerdown)
    else $error("disable format leaves buffer on");
  hold_code_a: assert property ( // R05
    @(posedge clock) disable iff (!rst_b)
    hld_reg[HOLD_LSB +: 2] != 2'h3)
    else $error("reserved hold code stored");
  disable_bit_a: assert property ( // R07
    @(posedge clock) disable iff (!rst_b)
    (clk_en && reg_wr && reg_addr == ADDR_POWERDOWN && reg_wdata[DISABLE_BIT])
      |=> output_buffer_powerdown ##0 !clock_output)
    else $error("disable bit did not power down buffer");
  divider_pd_a: assert property ( // R08
    @(posedge clock) disable iff (!rst_b)
    (pd_reg[DISABLE_BIT] || output_format_select == FMT_DISABLE)
      |-> output_divider_one_powerdown)
    else $error("divider left running with output off");
  reserved_ro_a: assert property ( // R11
    @(posedge clock) disable iff (!rst_b)
    (clk_en && reg_wr && reg_addr == ADDR_CMOS_DRIVE)
      |=> drv_reg[5:0] == RST_CMOS_DRIVE[5:0])
    else $error("reserved bits changed by write");
  always_on_a: assert property ( // R10
    @(posedge clock) disable iff (!rst_b)
    (output_always_running && !output_buffer_powerdown) |-> clock_output == held_clk)
    else $error("always-on output squelched");

  hold_low_c: cover property (@(posedge clock) disable iff (!rst_b)
    output_hold_active && !clock_output);
  squelch_c: cover property (@(posedge clock) disable iff (!rst_b) output_squelched);
  freeze_c: cover property (@(posedge clock) disable iff (!rst_b) oscillator_freeze_force);
endmodule : cocr_regs

//--- testbench/cocr_clock_sink.sv
/* Downstream receiver model: counts level changes of the output clock and
   keeps the shortest complete run. Assumes sampling on the system clock. */
`timescale 1ns/1ps
module cocr_clock_sink (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Received clock, run clear
  input wire logic clock_output,
  input wire logic clear,
  // Observations
  output logic [15:0] toggles,
  output logic [7:0] min_run
);
  logic last_reg;
  logic seen_reg;
  logic [7:0] run_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      toggles <= 16'h0;
      min_run <= 8'hff;
      seen_reg <= 1'b0;
      run_reg <= 8'h0;
      // Idle level of the output after reset, so no false edge follows
      last_reg <= 1'b0;
    end else begin
      last_reg <= clock_output;
      if (clear) begin
        min_run <= 8'hff;
        seen_reg <= 1'b0;
      end else if (clock_output != last_reg) begin
        toggles <= toggles + 16'h1;
        // First run after clear is partial
        if (seen_reg && run_reg < min_run) begin
          min_run <= run_reg;
        end
        seen_reg <= 1'b1;
        run_reg <= 8'h1;
      end else begin
        run_reg <= run_reg + 8'h1;
      end
    end
  end
endmodule : cocr_clock_sink

//--- testbench/tb_clock_output_control_regs.sv
/* Self-checking bench for the clock output control register slice.
   Assumes the package and the receiver model are compiled first. */
`timescale 1ns/1ps
module tb_clock_output_control_regs;
  import cocr_pkg::*;
  logic clock, rst_b, clk_en, reg_wr, reg_rd, clear, reg_hit;
  logic [7:0] reg_addr;
  cocr_byte_t reg_wdata, reg_rdata;
  logic internal_calibration, output_always_running, oscillator_freeze_force;
  logic output_buffer_powerdown, output_divider_one_powerdown, output_squelched;
  logic clock_output, clock_output_n, output_hold_active;
  logic [1:0] cmos_drive_strength;
  logic [2:0] output_format_select;
  logic [2:0] div = 3'h0;
  logic [15:0] toggles;
  logic [7:0] min_run;
  int err_total = 0;
  int checks = 0;
  int cycle_count = 0;
  localparam logic [7:0] ADDRS [6] = '{8'h03, 8'h05, 8'h06, 8'h08, 8'h0a, 8'h04};
  localparam logic [7:0] EXP_RST [6] = '{8'h05, 8'hed, 8'h2d, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] EXP_ONES [6] = '{8'h35, 8'hed, 8'h2f, 8'h00, 8'h04, 8'h00};
  localparam logic [7:0] EXP_ZERO [6] = '{8'h05, 8'h2d, 8'h28, 8'h00, 8'h00, 8'h00};

  cocr_regs DUT (
    .clock(clock), .rst_b(rst_b), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .internal_calibration(internal_calibration), .synth_clock(div[2]),
    .output_always_running(output_always_running),
    .oscillator_freeze_force(oscillator_freeze_force),
    .cmos_drive_strength(cmos_drive_strength), .output_format_select(output_format_select),
    .output_buffer_powerdown(output_buffer_powerdown),
    .output_divider_one_powerdown(output_divider_one_powerdown),
    .output_squelched(output_squelched), .clock_output(clock_output),
    .clock_output_n(clock_output_n), .output_hold_active(output_hold_active)
  );
  cocr_clock_sink sink (.clock(clock), .rst_b(rst_b), .clock_output(clock_output),
    .clear(clear), .toggles(toggles), .min_run(min_run));

  task automatic summarize;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // Extra edge so either read latency reading is covered
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    #1;
    d = reg_rdata;
  endtask : rd

  // Settle past sync latency, then count output changes
  task automatic watch(output logic [15:0] d);
    logic [15:0] t0;
    repeat (12) @(posedge clock);
    #1;
    t0 = toggles;
    repeat (40) @(posedge clock);
    // Read once the edge's updates have settled
    #1;
    d = toggles - t0;
  endtask : watch

  task automatic t_reset;
    logic [7:0] v;
    for (int i = 0; i < 5; i++) begin
      rd(ADDRS[i], v);
      chk(v, EXP_RST[i]);
    end
    chk(cmos_drive_strength, 8'h3);
    chk(output_format_select, 8'h5);
  endtask : t_reset

  task automatic t_regs;
    logic [7:0] v;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 6; i++) begin
        wr(ADDRS[i], p ? 8'h00 : 8'hff);
        rd(ADDRS[i], v);
        chk(v, p ? EXP_ZERO[i] : EXP_ONES[i]);
        chk(reg_hit, i < 5);
      end
    end
  endtask : t_regs

  task automatic t_ctrl;
    wr(ADDR_FREEZE_SQUELCH, 8'h20);
    chk(oscillator_freeze_force, 8'h1);
    wr(ADDR_FREEZE_SQUELCH, 8'h00);
    chk(oscillator_freeze_force, 8'h0);
    wr(ADDR_FORMAT, 8'h02);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CMOS_DRIVE, 8'(c << 6));
      chk(cmos_drive_strength, 8'(c));
    end
  endtask : t_ctrl

  task automatic t_format;
    logic [15:0] d;
    logic pd;
    for (int f = 0; f < 8; f++) begin
      pd = (f == 0 || f == 1 || f == 4);
      wr(ADDR_FORMAT, 8'(f));
      chk(output_format_select, 8'(f));
      chk(output_buffer_powerdown, pd);
      chk(output_divider_one_powerdown, pd);
      watch(d);
      chk(d != 0, !pd);
    end
  endtask : t_format

  task automatic t_disable;
    logic [15:0] d;
    wr(ADDR_FORMAT, 8'h05);
    wr(ADDR_POWERDOWN, 8'h04);
    chk(output_buffer_powerdown, 8'h1);
    chk(output_divider_one_powerdown, 8'h1);
    watch(d);
    chk(8'(d != 16'h0), 8'h0);
    chk(clock_output, 8'h0);
    wr(ADDR_POWERDOWN, 8'h00);
    chk(output_divider_one_powerdown, 8'h0);
    watch(d);
    chk(d != 0, 8'h1);
  endtask : t_disable

  task automatic t_squelch;
    logic [15:0] d;
    @(posedge clock);
    internal_calibration <= 1'b1;
    wr(ADDR_FREEZE_SQUELCH, 8'h10);
    watch(d);
    chk(output_squelched, 8'h1);
    chk(8'(d != 16'h0), 8'h0);
    @(posedge clock);
    output_always_running <= 1'b1;
    watch(d);
    chk(output_squelched, 8'h0);
    chk(d != 0, 8'h1);
    @(posedge clock);
    output_always_running <= 1'b0;
    wr(ADDR_FREEZE_SQUELCH, 8'h00);
    watch(d);
    chk(d != 0, 8'h1);
    @(posedge clock);
    internal_calibration <= 1'b0;
  endtask : t_squelch

  task automatic t_hold;
    logic [15:0] d;
    @(posedge clock);
    clear <= 1'b1;
    @(posedge clock);
    clear <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_LEVEL_HOLD, i ? 8'h20 : 8'h10);
      watch(d);
      chk(8'(d != 16'h0), 8'h0);
      chk(clock_output, 8'(i));
      chk(clock_output_n, 8'(1 - i));
      chk(output_hold_active, 8'h1);
      wr(ADDR_LEVEL_HOLD, 8'h00);
      watch(d);
      chk(d != 0, 8'h1);
      chk(output_hold_active, 8'h0);
    end
    chk(min_run >= 8'h4, 8'h1);
  endtask : t_hold

  // Enable low freezes the registers; a write made then is lost
  task automatic t_enable;
    @(posedge clock);
    clk_en <= 1'b0;
    wr(ADDR_POWERDOWN, 8'h04);
    @(posedge clock);
    clk_en <= 1'b1;
    #1;
    chk(output_buffer_powerdown, 8'h0);
    wr(ADDR_POWERDOWN, 8'h04);
    chk(output_buffer_powerdown, 8'h1);
  endtask : t_enable

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    internal_calibration = 1'b0;
    output_always_running = 1'b0;
    clear = 1'b0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    t_reset();
    t_regs();
    t_ctrl();
    t_format();
    t_disable();
    t_squelch();
    t_hold();
    t_enable();
    // Second reset in mid-run must restore every register
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    t_reset();
    summarize();
  end

  // Generated clock, eight system cycles a period; hang guard
  always @(posedge clock) begin
    div <= div + 3'h1;
    cycle_count <= cycle_count + 1;
    if (cycle_count == 20000) begin
      err_total++;
      summarize();
    end
  end
endmodule : tb_clock_output_control_regs
